// [tmc_map.vh]
`ifndef TMC_MAP_VH
`define TMC_MAP_VH
// ****************************************
// Clock and timing
// ****************************************
`define TMC_CLK_KHZ 25000
`define TMC_CLK_NS 40
`define TMC_INIT_MS 2000
`define TMC_INIT_CYC 26'h2FAF080
`define TMC_RST_MIN_NS 2000
`define TMC_RST_MIN_CYC ((`TMC_RST_MIN_NS + `TMC_CLK_NS - 1) / `TMC_CLK_NS)
// ****************************************
// Serial bus
// ****************************************
`define TMC_DEV_ADDR 7'h50
`define TMC_PAGE_CODES 8'h03
// ****************************************
// Register offsets
// ****************************************
`define TMC_OFS_STATUS 8'h02
`define TMC_OFS_FLAG_LOS 8'h03
`define TMC_OFS_FLAG_FAULT 8'h04
`define TMC_OFS_FLAG_AUX 8'h06
`define TMC_OFS_POWER 8'h5D
`define TMC_OFS_RECOVERY 8'h62
`define TMC_OFS_MASK_LOS 8'h64
`define TMC_OFS_MASK_FAULT 8'h65
`define TMC_OFS_MASK_AUX 8'h67
`define TMC_OFS_PAGE 8'h7F
`define TMC_OFS_EQ 8'hEA
`define TMC_OFS_EMPH 8'hEC
`define TMC_OFS_AMPL 8'hEE
// ****************************************
// Fields and reset values
// ****************************************
`define TMC_BIT_NOT_READY 0
`define TMC_BIT_POWER_DOWN 1
`define TMC_MAX_EQ 4'hA
`define TMC_MAX_EMPH 4'h7
`define TMC_MAX_AMPL 4'h3
`define TMC_RST_RECOVERY 8'h00
`define TMC_RST_CODES 16'h0000
`endif

// [tmc_mgmt_ctrl.v]
// Behaviour
// R1: Byte 98 bits 7..4 turn transmit clock recovery on for lanes 4..1.
// R2: Byte 98 bits 3..0 turn receive clock recovery on for lanes 4..1.
// R3: Receive amplitude codes 0..3 valid per lane, higher codes reserved.
// R4: Transmit equalization codes 0..10 dB valid per lane, higher reserved.
// R5: Receive emphasis codes 0..7 dB valid, top bit set reserved.
// R6: Fully functional within 2000 ms of power-on or reset release.
// R7: Reset pin low shorter than 2 us is ignored.
// R8: Serial bus answers within 2000 ms of power-on.
// R9: Clear not-ready bit and assert attention within 2000 ms.
// R10: Fully functional within 2000 ms after reset pin rises.
// R11: Low-power pin high enters low power within 100 us.
// R12: Attention asserts within 200 ms of any triggering condition.
// R13: Flags clear on read; attention releases within 500 us after.
// R14: Receive loss-of-signal sets its flag and attention within 100 ms.
// R15: Transmit fault sets its flag and attention within 200 ms.
// R16: Other conditions set their flag and attention within 200 ms.
// R17: Mask set inhibits, mask clear restores, attention within 100 ms.
// R18: Serial responses start within 100 us of module select.
// R19: Serial responses stop within 100 us of deselect.
// R20: Power-down bit set enters low power within 100 ms.
// R21: Power-down bit clear returns to functional within 300 ms.
// R22: Mask and power deadlines timed from end of the write.
// R23: Attention held while any unmasked flag stays set.
`include "tmc_map.vh"
module tmc_mgmt_ctrl #(
   parameter [25:0] INIT_CYCLES = `TMC_INIT_CYC
)(
   // Clock and reset
   input wire I_CORE_CLK,
   input wire I_ARST_N,
   // Sideband pins
   input wire I_MODULE_RESET_N,
   input wire I_MODULE_SELECT_N,
   input wire I_LOW_POWER_REQUEST,
   output wire O_ATTENTION_N,
   // Serial bus
   input wire I_SCL,
   input wire I_SDA,
   output wire O_SDA,
   output wire O_SDA_OE_N,
   // Condition inputs
   input wire [3:0] I_RX_LOS,
   input wire [3:0] I_TX_FAULT,
   input wire [3:0] I_AUX_COND,
   // Lane controls
   output wire [3:0] O_TX_RECOVERY_ON,
   output wire [3:0] O_RX_RECOVERY_ON,
   output wire [15:0] O_TX_EQ,
   output wire [15:0] O_RX_EMPH,
   output wire [15:0] O_RX_AMPL,
   // Module state
   output reg O_LOW_POWER,
   output wire O_READY
);
   // ****************************************
   // Declarations
   // ****************************************
   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_ADDR = 4'h1;
   localparam [3:0] ST_AACK = 4'h2;
   localparam [3:0] ST_REG = 4'h3;
   localparam [3:0] ST_WACK = 4'h4;
   localparam [3:0] ST_WDATA = 4'h5;
   localparam [3:0] ST_RDATA = 4'h6;
   localparam [3:0] ST_MACK = 4'h7;
   localparam integer RST_MIN_I = `TMC_RST_MIN_CYC;
   localparam [5:0] RST_MIN = RST_MIN_I[5:0];
   reg [5:0] rst_cnt_r;
   reg mod_rst_r;
   reg [25:0] init_cnt_r;
   reg not_ready_r;
   reg ready_flag_r;
   reg [7:0] recovery_r;
   reg [15:0] eq_r;
   reg [15:0] emph_r;
   reg [15:0] ampl_r;
   reg [7:0] page_r;
   reg power_down_r;
   reg [3:0] los_r;
   reg [3:0] fault_r;
   reg [3:0] aux_r;
   reg [3:0] mask_los_r;
   reg [3:0] mask_fault_r;
   reg [3:0] mask_aux_r;
   reg scl_q;
   reg sda_q;
   reg [3:0] state_r;
   reg [2:0] bit_cnt_r;
   reg got_byte_r;
   reg [7:0] shreg_r;
   reg [7:0] ptr_r;
   reg rw_r;
   reg nack_r;
   reg drive_low_r;
   reg [7:0] rd_byte;
   reg [3:0] los_clr;
   reg [3:0] fault_clr;
   reg [3:0] aux_clr;
   reg ready_clr;
   wire selected = ~I_MODULE_SELECT_N & ~mod_rst_r;
   wire scl_rise = I_SCL & ~scl_q;
   wire scl_fall = ~I_SCL & scl_q;
   wire bus_start = scl_q & I_SCL & sda_q & ~I_SDA;
   wire bus_stop = scl_q & I_SCL & ~sda_q & I_SDA;
   wire upper_p3 = ptr_r[7] & (page_r == `TMC_PAGE_CODES);
   wire rd_load = (scl_fall & state_r == ST_AACK & rw_r) |
                  (scl_fall & state_r == ST_MACK & ~nack_r);
   wire wr_stb = scl_fall & state_r == ST_WDATA & got_byte_r;
   // ****************************************
   // Functions
   // ****************************************
   function [7:0] nib_upd;
      input [7:0] old_b;
      input [7:0] new_b;
      input [3:0] lim;
      begin
         nib_upd[7:4] = (new_b[7:4] <= lim) ? new_b[7:4] : old_b[7:4];
         nib_upd[3:0] = (new_b[3:0] <= lim) ? new_b[3:0] : old_b[3:0];
      end
   endfunction
   // ****************************************
   // Reset pin filter and init timer
   // ****************************************
   always @(posedge I_CORE_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         rst_cnt_r <= 6'h00;
         mod_rst_r <= 1'b0;
      end
      else if (I_MODULE_RESET_N)
      begin
         rst_cnt_r <= 6'h00;
         mod_rst_r <= 1'b0;
      end
      else if (rst_cnt_r < RST_MIN - 6'h01)
         rst_cnt_r <= rst_cnt_r + 6'h01; // R7
      else
         mod_rst_r <= 1'b1; // R7
   end
   always @(posedge I_CORE_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         init_cnt_r <= 26'h0000000;
         not_ready_r <= 1'b1;
         ready_flag_r <= 1'b0;
      end
      else if (mod_rst_r)
      begin
         init_cnt_r <= 26'h0000000;
         not_ready_r <= 1'b1;
         ready_flag_r <= 1'b0;
      end
      else if (not_ready_r)
      begin
         if (init_cnt_r >= INIT_CYCLES - 26'h0000001)
         begin
            not_ready_r <= 1'b0; // R6 R9 R10
            ready_flag_r <= 1'b1; // R9
         end
         else
            init_cnt_r <= init_cnt_r + 26'h0000001;
      end
      else if (ready_clr)
         ready_flag_r <= 1'b0; // R13
   end
   assign O_READY = ~not_ready_r;
   // ****************************************
   // Read mux and clear-on-read
   // ****************************************
   always @*
   begin
      rd_byte = 8'h00;
      los_clr = 4'h0;
      fault_clr = 4'h0;
      aux_clr = 4'h0;
      ready_clr = 1'b0;
      if (upper_p3)
      begin
         case (ptr_r)
            `TMC_OFS_EQ: rd_byte = eq_r[15:8];
            `TMC_OFS_EQ + 8'h01: rd_byte = eq_r[7:0];
            `TMC_OFS_EMPH: rd_byte = emph_r[15:8];
            `TMC_OFS_EMPH + 8'h01: rd_byte = emph_r[7:0];
            `TMC_OFS_AMPL: rd_byte = ampl_r[15:8];
            `TMC_OFS_AMPL + 8'h01: rd_byte = ampl_r[7:0];
            default: rd_byte = 8'h00;
         endcase
      end
      else
      begin
         case (ptr_r)
            `TMC_OFS_STATUS:
            begin
               rd_byte = {7'h00, not_ready_r};
               ready_clr = rd_load; // R13
            end
            `TMC_OFS_FLAG_LOS:
            begin
               rd_byte = {4'h0, los_r};
               los_clr = rd_load ? los_r : 4'h0; // R13
            end
            `TMC_OFS_FLAG_FAULT:
            begin
               rd_byte = {4'h0, fault_r};
               fault_clr = rd_load ? fault_r : 4'h0; // R13
            end
            `TMC_OFS_FLAG_AUX:
            begin
               rd_byte = {4'h0, aux_r};
               aux_clr = rd_load ? aux_r : 4'h0; // R13
            end
            `TMC_OFS_POWER: rd_byte = {6'h00, power_down_r, 1'b0};
            `TMC_OFS_RECOVERY: rd_byte = recovery_r;
            `TMC_OFS_MASK_LOS: rd_byte = {4'h0, mask_los_r};
            `TMC_OFS_MASK_FAULT: rd_byte = {4'h0, mask_fault_r};
            `TMC_OFS_MASK_AUX: rd_byte = {4'h0, mask_aux_r};
            `TMC_OFS_PAGE: rd_byte = page_r;
            default: rd_byte = 8'h00;
         endcase
      end
   end
   // ****************************************
   // Registers and flags
   // ****************************************
   always @(posedge I_CORE_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         recovery_r <= `TMC_RST_RECOVERY;
         eq_r <= `TMC_RST_CODES;
         emph_r <= `TMC_RST_CODES;
         ampl_r <= `TMC_RST_CODES;
         page_r <= 8'h00;
         power_down_r <= 1'b0;
         mask_los_r <= 4'h0;
         mask_fault_r <= 4'h0;
         mask_aux_r <= 4'h0;
         los_r <= 4'h0;
         fault_r <= 4'h0;
         aux_r <= 4'h0;
      end
      else if (mod_rst_r)
      begin
         recovery_r <= `TMC_RST_RECOVERY;
         eq_r <= `TMC_RST_CODES;
         emph_r <= `TMC_RST_CODES;
         ampl_r <= `TMC_RST_CODES;
         page_r <= 8'h00;
         power_down_r <= 1'b0;
         mask_los_r <= 4'h0;
         mask_fault_r <= 4'h0;
         mask_aux_r <= 4'h0;
         los_r <= 4'h0;
         fault_r <= 4'h0;
         aux_r <= 4'h0;
      end
      else
      begin
         los_r <= (los_r & ~los_clr) | I_RX_LOS; // R14 R13
         fault_r <= (fault_r & ~fault_clr) | I_TX_FAULT; // R15 R13
         aux_r <= (aux_r & ~aux_clr) | I_AUX_COND; // R16 R13
         if (wr_stb & upper_p3)
         begin
            case (ptr_r)
               `TMC_OFS_EQ: eq_r[15:8] <= nib_upd(eq_r[15:8], shreg_r, `TMC_MAX_EQ); // R4
               `TMC_OFS_EQ + 8'h01: eq_r[7:0] <= nib_upd(eq_r[7:0], shreg_r, `TMC_MAX_EQ); // R4
               `TMC_OFS_EMPH: emph_r[15:8] <= nib_upd(emph_r[15:8], shreg_r, `TMC_MAX_EMPH); // R5
               `TMC_OFS_EMPH + 8'h01: emph_r[7:0] <= nib_upd(emph_r[7:0], shreg_r, `TMC_MAX_EMPH); // R5
               `TMC_OFS_AMPL: ampl_r[15:8] <= nib_upd(ampl_r[15:8], shreg_r, `TMC_MAX_AMPL); // R3
               `TMC_OFS_AMPL + 8'h01: ampl_r[7:0] <= nib_upd(ampl_r[7:0], shreg_r, `TMC_MAX_AMPL); // R3
               default: page_r <= page_r;
            endcase
         end
         else if (wr_stb)
         begin
            case (ptr_r)
               `TMC_OFS_POWER: power_down_r <= shreg_r[`TMC_BIT_POWER_DOWN]; // R20 R21 R22
               `TMC_OFS_RECOVERY: recovery_r <= shreg_r; // R1 R2
               `TMC_OFS_MASK_LOS: mask_los_r <= shreg_r[3:0]; // R17 R22
               `TMC_OFS_MASK_FAULT: mask_fault_r <= shreg_r[3:0]; // R17 R22
               `TMC_OFS_MASK_AUX: mask_aux_r <= shreg_r[3:0]; // R17 R22
               `TMC_OFS_PAGE: page_r <= shreg_r;
               default: page_r <= page_r;
            endcase
         end
      end
   end
   assign O_TX_RECOVERY_ON = recovery_r[7:4]; // R1
   assign O_RX_RECOVERY_ON = recovery_r[3:0]; // R2
   assign O_TX_EQ = eq_r;
   assign O_RX_EMPH = emph_r;
   assign O_RX_AMPL = ampl_r;
   assign O_ATTENTION_N = ~(ready_flag_r | |(los_r & ~mask_los_r) |
                            |(fault_r & ~mask_fault_r) | |(aux_r & ~mask_aux_r)); // R12 R17 R23
   always @(posedge I_CORE_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
         O_LOW_POWER <= 1'b0;
      else
         O_LOW_POWER <= I_LOW_POWER_REQUEST | power_down_r; // R11 R20 R21
   end
   // ****************************************
   // Serial bus slave
   // ****************************************
   always @(posedge I_CORE_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         state_r <= ST_IDLE;
         bit_cnt_r <= 3'h0;
         got_byte_r <= 1'b0;
         shreg_r <= 8'h00;
         ptr_r <= 8'h00;
         rw_r <= 1'b0;
         nack_r <= 1'b0;
         drive_low_r <= 1'b0;
      end
      else
      begin
         scl_q <= I_SCL;
         sda_q <= I_SDA;
         if (!selected | bus_stop)
         begin
            state_r <= ST_IDLE; // R19
            drive_low_r <= 1'b0;
         end
         else if (bus_start)
         begin
            state_r <= ST_ADDR; // R8 R18
            bit_cnt_r <= 3'h0;
            got_byte_r <= 1'b0;
            drive_low_r <= 1'b0;
         end
         else if (scl_rise)
         begin
            case (state_r)
               ST_ADDR, ST_REG, ST_WDATA:
               begin
                  shreg_r <= {shreg_r[6:0], I_SDA};
                  bit_cnt_r <= bit_cnt_r + 3'h1;
                  got_byte_r <= (bit_cnt_r == 3'h7);
               end
               ST_RDATA:
               begin
                  bit_cnt_r <= bit_cnt_r + 3'h1;
                  got_byte_r <= (bit_cnt_r == 3'h7);
               end
               ST_MACK: nack_r <= I_SDA;
               default: nack_r <= nack_r;
            endcase
         end
         else if (scl_fall)
         begin
            case (state_r)
               ST_ADDR:
               begin
                  if (got_byte_r & shreg_r[7:1] == `TMC_DEV_ADDR)
                  begin
                     state_r <= ST_AACK;
                     rw_r <= shreg_r[0];
                     drive_low_r <= 1'b1;
                  end
                  else if (got_byte_r)
                     state_r <= ST_IDLE;
                  got_byte_r <= 1'b0;
               end
               ST_AACK, ST_MACK:
               begin
                  if (rd_load)
                  begin
                     shreg_r <= rd_byte;
                     drive_low_r <= ~rd_byte[7];
                     ptr_r <= ptr_r + 8'h01;
                     state_r <= ST_RDATA;
                  end
                  else
                  begin
                     drive_low_r <= 1'b0;
                     state_r <= (state_r == ST_AACK) ? ST_REG : ST_IDLE;
                  end
                  bit_cnt_r <= 3'h0;
               end
               ST_REG, ST_WDATA:
               begin
                  if (got_byte_r)
                  begin
                     if (state_r == ST_REG)
                        ptr_r <= shreg_r;
                     else
                        ptr_r <= ptr_r + 8'h01;
                     drive_low_r <= 1'b1;
                     state_r <= ST_WACK;
                  end
                  got_byte_r <= 1'b0;
               end
               ST_WACK:
               begin
                  drive_low_r <= 1'b0;
                  state_r <= ST_WDATA;
               end
               ST_RDATA:
               begin
                  if (got_byte_r)
                  begin
                     drive_low_r <= 1'b0;
                     state_r <= ST_MACK;
                  end
                  else
                  begin
                     shreg_r <= {shreg_r[6:0], 1'b0};
                     drive_low_r <= ~shreg_r[6];
                  end
                  got_byte_r <= 1'b0;
               end
               default: state_r <= ST_IDLE;
            endcase
         end
      end
   end
   assign O_SDA = 1'b0;
   assign O_SDA_OE_N = ~drive_low_r;
endmodule

// [tmc_host.sv]
module tmc_host (
   // Bus lines
   input wire logic clk,
   input wire logic sda_in,
   output logic scl = 1'b1,
   output logic sda_out = 1'b1
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // Two-wire bus master, changes after core clock falls
   // ****************************************
   logic acked = 1'b0;
   task automatic tk(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic bit_c(input logic v, output logic s);
      sda_out = v;
      tk(2);
      scl = 1'b1;
      tk(2);
      s = sda_in;
      tk(2);
      scl = 1'b0;
      tk(2);
   endtask
   task automatic start_c();
      sda_out = 1'b1;
      tk(2);
      scl = 1'b1;
      tk(2);
      sda_out = 1'b0;
      tk(2);
      scl = 1'b0;
      tk(2);
   endtask
   task automatic stop_c();
      sda_out = 1'b0;
      tk(2);
      scl = 1'b1;
      tk(2);
      sda_out = 1'b1;
      tk(4);
   endtask
   task automatic put_b(input logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_c(b[i], s);
      bit_c(1'b1, s);
      acked = ~s;
   endtask
   task automatic wr_reg(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d);
      start_c();
      put_b({a, 1'b0});
      put_b(o);
      put_b(d);
      stop_c();
   endtask
   task automatic rd_reg(input logic [6:0] a, input logic [7:0] o, output logic [7:0] d);
      logic s;
      start_c();
      put_b({a, 1'b0});
      put_b(o);
      start_c();
      put_b({a, 1'b1});
      for (int i = 7; i >= 0; i--)
         bit_c(1'b1, d[i]);
      bit_c(1'b1, s);
      stop_c();
   endtask
endmodule

// [tmc_mgmt_ctrl_asserts.sv]
module tmc_mgmt_ctrl_asserts #(
   parameter [25:0] INIT_CYCLES = 26'h14
)(
   // Watched ports
   input wire I_CORE_CLK,
   input wire I_ARST_N,
   input wire I_MODULE_RESET_N,
   input wire I_MODULE_SELECT_N,
   input wire I_LOW_POWER_REQUEST,
   input wire O_ATTENTION_N,
   input wire I_SCL,
   input wire I_SDA,
   input wire O_SDA,
   input wire O_SDA_OE_N,
   input wire [3:0] I_RX_LOS,
   input wire [3:0] I_TX_FAULT,
   input wire [3:0] I_AUX_COND,
   input wire [3:0] O_TX_RECOVERY_ON,
   input wire [3:0] O_RX_RECOVERY_ON,
   input wire [15:0] O_TX_EQ,
   input wire [15:0] O_RX_EMPH,
   input wire [15:0] O_RX_AMPL,
   input wire O_LOW_POWER,
   input wire O_READY
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] low_cnt;
   logic [31:0] wait_cnt;
   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
      if (!I_ARST_N)
         low_cnt <= 8'h00;
      else if (I_MODULE_RESET_N)
         low_cnt <= 8'h00;
      else if (low_cnt != 8'hFF)
         low_cnt <= low_cnt + 8'h01;
   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
      if (!I_ARST_N)
         wait_cnt <= 32'h0;
      else
         wait_cnt <= (!O_READY && I_MODULE_RESET_N) ? wait_cnt + 32'h1 : 32'h0;
   function automatic logic eq_ok(input logic [15:0] v);
      return v[15:12] <= 4'hA && v[11:8] <= 4'hA && v[7:4] <= 4'hA && v[3:0] <= 4'hA;
   endfunction
   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge I_CORE_CLK);
   endclocking
   default disable iff (!I_ARST_N);
   sequence deselect_s;
      I_MODULE_SELECT_N [*3];
   endsequence
   sequence lp_rise_s;
      $rose(I_LOW_POWER_REQUEST);
   endsequence
   property oe_on_fall_p;
      $changed(O_SDA_OE_N) && !I_MODULE_SELECT_N && $past(!I_MODULE_SELECT_N)
         && I_MODULE_RESET_N |-> !$past(I_SCL);
   endproperty
   sel_idle_a: assert property (deselect_s |-> O_SDA_OE_N)
      else $error("data line driven while deselected");
   lp_entry_a: assert property (lp_rise_s |-> ##[1:2] O_LOW_POWER)
      else $error("low power pin not followed");
   ready_att_a: assert property ($rose(O_READY) |-> !O_ATTENTION_N)
      else $error("ready without attention");
   init_bound_a: assert property ((!O_READY && I_MODULE_RESET_N) |-> wait_cnt <= INIT_CYCLES + 2)
      else $error("initialisation too long");
   soft_rst_a: assert property ($fell(O_READY) |-> low_cnt >= 8'h30)
      else $error("short reset pulse acted");
   oe_fall_a: assert property (oe_on_fall_p)
      else $error("data line changed while clock high");
   ampl_code_a: assert property ((O_RX_AMPL & 16'hCCCC) == 16'h0000)
      else $error("reserved amplitude code held");
   emph_code_a: assert property ((O_RX_EMPH & 16'h8888) == 16'h0000)
      else $error("reserved emphasis code held");
   eq_code_a: assert property (eq_ok(O_TX_EQ))
      else $error("reserved equalization code held");
endmodule
bind tmc_mgmt_ctrl tmc_mgmt_ctrl_asserts #(.INIT_CYCLES(INIT_CYCLES)) i_asserts (
   .I_CORE_CLK(I_CORE_CLK), .I_ARST_N(I_ARST_N), .I_MODULE_RESET_N(I_MODULE_RESET_N),
   .I_MODULE_SELECT_N(I_MODULE_SELECT_N), .I_LOW_POWER_REQUEST(I_LOW_POWER_REQUEST),
   .O_ATTENTION_N(O_ATTENTION_N), .I_SCL(I_SCL), .I_SDA(I_SDA), .O_SDA(O_SDA),
   .O_SDA_OE_N(O_SDA_OE_N), .I_RX_LOS(I_RX_LOS), .I_TX_FAULT(I_TX_FAULT),
   .I_AUX_COND(I_AUX_COND), .O_TX_RECOVERY_ON(O_TX_RECOVERY_ON),
   .O_RX_RECOVERY_ON(O_RX_RECOVERY_ON), .O_TX_EQ(O_TX_EQ), .O_RX_EMPH(O_RX_EMPH),
   .O_RX_AMPL(O_RX_AMPL), .O_LOW_POWER(O_LOW_POWER), .O_READY(O_READY));

// [tmc_mgmt_ctrl_bench.sv]
`include "tmc_map.vh"
module tmc_mgmt_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam [25:0] INIT = 26'h14;
   localparam [23:0] ROWS [12] = '{24'h62F0F0, 24'h620F0F, 24'h62A5A5, 24'hEAA0A0,
      24'hEAB1A1, 24'hEB5A5A, 24'hEBCF5A, 24'hEC7070, 24'hEC8777, 24'hEE3030,
      24'hEE4333, 24'hEF1212};
   localparam [7:0] FLG [3] = '{8'h03, 8'h04, 8'h06};
   localparam [7:0] MSK [3] = '{8'h64, 8'h65, 8'h67};
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic rst_pin_n = 1'b1;
   logic sel_n = 1'b0;
   logic lp_req = 1'b0;
   logic [3:0] los = 4'h0;
   logic [3:0] flt = 4'h0;
   logic [3:0] aux = 4'h0;
   logic [7:0] rd;
   logic scl, sda_h;
   wire sda_o, sda_oe_n, att_n, lowp, rdy;
   wire [3:0] txr, rxr;
   wire [15:0] eq, emph, ampl;
   wire sda_w = sda_h & (sda_oe_n | sda_o);
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;
   always #20 core_clk = ~core_clk;
   tmc_mgmt_ctrl #(.INIT_CYCLES(INIT)) i_dut (
      .I_CORE_CLK(core_clk), .I_ARST_N(arst_n), .I_MODULE_RESET_N(rst_pin_n),
      .I_MODULE_SELECT_N(sel_n), .I_LOW_POWER_REQUEST(lp_req), .O_ATTENTION_N(att_n),
      .I_SCL(scl), .I_SDA(sda_w), .O_SDA(sda_o), .O_SDA_OE_N(sda_oe_n),
      .I_RX_LOS(los), .I_TX_FAULT(flt), .I_AUX_COND(aux), .O_TX_RECOVERY_ON(txr),
      .O_RX_RECOVERY_ON(rxr), .O_TX_EQ(eq), .O_RX_EMPH(emph), .O_RX_AMPL(ampl),
      .O_LOW_POWER(lowp), .O_READY(rdy));
   tmc_host i_host (.clk(core_clk), .sda_in(sda_w), .scl(scl), .sda_out(sda_h));
   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk(input logic [55:0] got, input logic [55:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         fails++;
         conclude();
      end
   end
   task automatic wr(input logic [7:0] o, input logic [7:0] d);
      i_host.wr_reg(`TMC_DEV_ADDR, o, d);
   endtask
   task automatic rdb(input logic [7:0] o);
      i_host.rd_reg(`TMC_DEV_ADDR, o, rd);
   endtask
   task automatic pulse(input int k);
      los = (k == 0) ? 4'h4 : 4'h0;
      flt = (k == 1) ? 4'h4 : 4'h0;
      aux = (k == 2) ? 4'h4 : 4'h0;
      i_host.tk(2);
      los = 4'h0;
      flt = 4'h0;
      aux = 4'h0;
      i_host.tk(2);
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      repeat (5) @(negedge core_clk);
      arst_n = 1'b1;
      chk({rdy, att_n, txr, rxr}, 10'h100);
      i_host.tk(INIT + 2);
      chk({rdy, att_n}, 2'h2);
      rdb(8'h02);
      chk({i_host.acked, rd[0], att_n}, 3'h5);
      wr(8'h7F, 8'h03);
      foreach (ROWS[i])
      begin
         wr(ROWS[i][23:16], ROWS[i][15:8]);
         rdb(ROWS[i][23:16]);
         chk(rd, ROWS[i][7:0]);
      end
      chk({txr, rxr, eq, emph, ampl}, 56'hA5A15A77003312);
      for (int k = 0; k < 3; k++)
      begin
         pulse(k);
         chk(att_n, 1'b0);
         rdb(FLG[k]);
         chk({rd, att_n}, 9'h009);
         wr(MSK[k], 8'h04);
         pulse(k);
         chk(att_n, 1'b1);
         wr(MSK[k], 8'h00);
         i_host.tk(2);
         chk(att_n, 1'b0);
         rdb(FLG[k]);
         chk({rd, att_n}, 9'h009);
      end
      los = 4'h1;
      flt = 4'h2;
      i_host.tk(2);
      los = 4'h0;
      flt = 4'h0;
      rdb(8'h03);
      chk({rd, att_n}, 9'h002);
      rdb(8'h04);
      chk({rd, att_n}, 9'h005);
      los = 4'hE;
      flt = 4'hD;
      aux = 4'hB;
      i_host.tk(2);
      los = 4'h0;
      flt = 4'h0;
      aux = 4'h0;
      rdb(8'h03);
      chk({rd, att_n}, 9'h01C);
      rdb(8'h04);
      chk({rd, att_n}, 9'h01A);
      rdb(8'h06);
      chk({rd, att_n}, 9'h017);
      lp_req = 1'b1;
      i_host.tk(3);
      chk(lowp, 1'b1);
      lp_req = 1'b0;
      i_host.tk(3);
      chk(lowp, 1'b0);
      wr(8'h5D, 8'h02);
      chk(lowp, 1'b1);
      wr(8'h5D, 8'h00);
      chk({lowp, rdy}, 2'h1);
      sel_n = 1'b1;
      i_host.tk(3);
      wr(8'h62, 8'h11);
      chk({i_host.acked, txr, rxr}, 9'h0A5);
      sel_n = 1'b0;
      i_host.tk(3);
      wr(8'h62, 8'h3C);
      chk({i_host.acked, txr, rxr}, 9'h13C);
      i_host.wr_reg(7'h51, 8'h62, 8'hFF);
      chk({i_host.acked, txr, rxr}, 9'h03C);
      rst_pin_n = 1'b0;
      i_host.tk(10);
      rst_pin_n = 1'b1;
      i_host.tk(2);
      chk({rdy, txr, rxr}, 9'h13C);
      rst_pin_n = 1'b0;
      i_host.tk(60);
      chk({rdy, txr, rxr}, 9'h000);
      rst_pin_n = 1'b1;
      i_host.tk(INIT + 3);
      chk({rdy, att_n}, 2'h2);
      rdb(8'h02);
      chk({rdy, att_n}, 2'h3);
      conclude();
   end
endmodule
